// *** design/pllcs_top.sv ***
// Clock synthesizer control and glitch-free processor clock selection
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Processor clock comes from reference, synthesizer or ring oscillator.
// - After power-up the reference drives the clock, output equals reference.
// - Halt and slow-clock overrides beat the synthesizer selection.
// - Without a reference clock the synthesizer produces nothing.
// - Lock flag sets once locked, then lock detection stops.
// - Select bit moves clock to VCO divided by two without glitches.
// - Clearing select returns the clock to a 1X reference copy.
// - Each control write clears lock and restarts toward new set point.
// - VCO equals reference times M over N; N 3-bit, M 5-bit codes.
// - M code is M-2; N code is 7 for N=1, else N-2.
// - Power-enable bit powers the synthesizer up or down.
// - Reset clears control, synthesizer deselected and powered down.
// - Source switches take a few cycles; old clock runs meanwhile.
// - Ring select uses ring oscillator, synchronised; oscillator off otherwise.
// - Halt synchronously stops the processor clock; synthesizer keeps running.
module pllcs_top
    import pllcs_pkg::*;
#(
    parameter int LOCK_EDGES = PLLCS_LOCK_EDGES,
    parameter int RING_HALF  = PLLCS_RING_HALF
) (
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    input  wire logic                    ref_clock_in,
    input  wire logic                    ctrl_write,
    input  wire logic [PLLCS_CTRL_W-1:0] ctrl_wdata,
    input  wire logic                    ring_osc_select,
    input  wire logic                    clock_halt,
    output logic                         proc_clock,
    output logic                         clock_out_pin,
    output logic                         loop_locked,
    output logic                         pll_select,
    output logic                         pll_power_enable,
    output logic [PLLCS_LF_W-1:0]        loop_filter_setting,
    output logic [PLLCS_CTRL_W-1:0]      ctrl_rdata,
    output pllcs_src_t                   clock_source,
    output logic                         ring_osc_enable
);
    function automatic logic [PLLCS_M_W-1:0] m_from_code(input logic [PLLCS_M_W-1:0] code);
        m_from_code = code + PLLCS_M_OFFSET;
    endfunction : m_from_code

    function automatic logic [PLLCS_NV_W-1:0] n_from_code(input logic [PLLCS_N_W-1:0] code);
        n_from_code = (code == PLLCS_N_CODE_ONE) ? PLLCS_N_ONE : ({1'b0, code} + PLLCS_N_OFFSET);
    endfunction : n_from_code

    pllcs_if link ();

    logic                    ref_meta;
    logic                    ref_sync;
    logic                    ref_prev;
    logic [PLLCS_CTRL_W-1:0] ctrl;
    logic [PLLCS_RING_W-1:0] ring_cnt;
    logic                    ring_level;
    logic                    gate_open;
    pllcs_src_t              active;

    wire pllcs_src_t target    = ring_osc_select ? PLLCS_SRC_RING :
                                 ctrl[PLLCS_SEL_BIT] ? PLLCS_SRC_PLL : PLLCS_SRC_REF;
    wire                     pll_level = link.vco_half;
    wire                     cur_level = (active == PLLCS_SRC_RING) ? ring_level :
                                         (active == PLLCS_SRC_PLL) ? pll_level : ref_sync;
    wire                     tgt_level = (target == PLLCS_SRC_RING) ? ring_level :
                                         (target == PLLCS_SRC_PLL) ? pll_level : ref_sync;
    // Switch only while both sources are low, so no short pulse escapes
    wire                     do_switch = (target != active) && !cur_level && !tgt_level;
    wire                     next_gate = cur_level ? gate_open : !clock_halt;
    wire                     next_clk  = cur_level & next_gate;
    wire                     ring_wrap = (ring_cnt == PLLCS_RING_W'(RING_HALF - 1));

    assign link.power     = ctrl[PLLCS_EN_BIT];
    assign link.restart   = ctrl_write;
    assign link.ref_rise  = ref_sync & ~ref_prev;
    assign link.m_val     = m_from_code(ctrl[PLLCS_M_LSB +: PLLCS_M_W]);
    assign link.n_val     = n_from_code(ctrl[PLLCS_N_LSB +: PLLCS_N_W]);

    pllcs_core #(
        .LOCK_EDGES (LOCK_EDGES)
    ) u_core (
        .clk_sys (clk_sys),
        .reset   (reset),
        .bus     (link.core)
    );

    // Pin input passes two flops first
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ref_meta <= 1'b0;
            ref_sync <= 1'b0;
            ref_prev <= 1'b0;
        end else begin
            ref_meta <= ref_clock_in;
            ref_sync <= ref_meta;
            ref_prev <= ref_sync;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl <= PLLCS_CTRL_RESET;
        end else if (ctrl_write) begin
            ctrl <= ctrl_wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ring_cnt   <= '0;
            ring_level <= 1'b0;
        end else if (!ring_osc_select) begin
            ring_cnt   <= '0;
            ring_level <= 1'b0;
        end else if (ring_wrap) begin
            ring_cnt   <= '0;
            ring_level <= ~ring_level;
        end else begin
            ring_cnt   <= ring_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            active <= PLLCS_SRC_REF;
        end else if (do_switch) begin
            active <= target;
        end
    end

    // halt gate applied at low phase
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            gate_open     <= 1'b1;
            proc_clock    <= 1'b0;
            clock_out_pin <= 1'b0;
        end else begin
            gate_open     <= next_gate;
            proc_clock    <= next_clk;
            clock_out_pin <= next_clk;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            loop_locked         <= 1'b0;
            pll_select          <= 1'b0;
            pll_power_enable    <= 1'b0;
            loop_filter_setting <= '0;
            ctrl_rdata          <= PLLCS_CTRL_RESET;
            clock_source        <= PLLCS_SRC_REF;
            ring_osc_enable     <= 1'b0;
        end else begin
            loop_locked         <= link.lock & ctrl[PLLCS_EN_BIT] & ~ctrl_write;
            pll_select          <= ctrl_write ? ctrl_wdata[PLLCS_SEL_BIT] : ctrl[PLLCS_SEL_BIT];
            pll_power_enable    <= ctrl_write ? ctrl_wdata[PLLCS_EN_BIT] : ctrl[PLLCS_EN_BIT];
            loop_filter_setting <= ctrl_write ? ctrl_wdata[PLLCS_LF_LSB +: PLLCS_LF_W] :
                                                ctrl[PLLCS_LF_LSB +: PLLCS_LF_W];
            ctrl_rdata          <= ctrl_write ? ctrl_wdata : ctrl;
            clock_source        <= do_switch ? target : active;
            ring_osc_enable     <= ring_osc_select;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence write_seen;
        ctrl_write;
    endsequence

    sequence lock_low_after;
        ##1 !loop_locked;
    endsequence

    lock_clear_a: assert property (write_seen |-> lock_low_after)
        else $error("lock flag survived a control write");
    lock_power_a: assert property (!pll_power_enable |-> !loop_locked)
        else $error("lock flag set while powered down");
    ref_follow_a: assert property (
        active == PLLCS_SRC_REF && !do_switch && gate_open && !clock_halt
        |=> proc_clock == $past(ref_sync))
        else $error("processor clock not following reference");
    halt_hold_a: assert property (
        clock_halt && !proc_clock && !cur_level |=> !proc_clock [*2])
        else $error("clock ran while halted");
    switch_target_a: assert property (active != $past(active) |-> active == $past(target))
        else $error("switched to a source other than the target");
    ring_off_a: assert property (!ring_osc_select |=> ring_cnt == '0 && !ring_level)
        else $error("ring oscillator running while deselected");
    no_glitch_a: assert property (active != $past(active) |-> !proc_clock)
        else $error("clock high across a source switch");
    // The switch never waits for lock, so the switch is bounded on the target alone
    pll_switch_a: assert property (
        target == PLLCS_SRC_PLL && active != PLLCS_SRC_PLL
        |-> ##[1:1000] (active == PLLCS_SRC_PLL || target != PLLCS_SRC_PLL))
        else $error("switch to synthesizer clock never completed");
    ref_return_a: assert property (
        target == PLLCS_SRC_REF && active == PLLCS_SRC_PLL
        |-> ##[1:1000] (active == PLLCS_SRC_REF || target != PLLCS_SRC_REF))
        else $error("switch back to reference never completed");
    m_decode_a: assert property (
        link.m_val == ctrl[PLLCS_M_LSB +: PLLCS_M_W] + PLLCS_M_OFFSET)
        else $error("feedback divider decode wrong");
    out_match_a: assert property (clock_out_pin == proc_clock)
        else $error("clock output differs from processor clock");
endmodule : pllcs_top
`default_nettype wire

// *** design/pllcs_pkg.sv ***
// Constants and types shared by the clock synthesizer modules
package pllcs_pkg;
    localparam int          PLLCS_CTRL_W      = 16;
    localparam logic [15:0] PLLCS_CTRL_RESET  = 16'h0000;
    localparam int          PLLCS_M_LSB       = 0;
    localparam int          PLLCS_M_W         = 5;
    localparam int          PLLCS_N_LSB       = 5;
    localparam int          PLLCS_N_W         = 3;
    localparam int          PLLCS_LF_LSB      = 8;
    localparam int          PLLCS_LF_W        = 4;
    localparam int          PLLCS_SEL_BIT     = 14;
    localparam int          PLLCS_EN_BIT      = 15;
    localparam logic [2:0]  PLLCS_N_CODE_ONE  = 3'h7;
    localparam logic [4:0]  PLLCS_M_OFFSET    = 5'h02;
    localparam logic [3:0]  PLLCS_N_OFFSET    = 4'h2;
    localparam logic [3:0]  PLLCS_N_ONE       = 4'h1;
    localparam int          PLLCS_NV_W        = 4;
    localparam int          PLLCS_PER_W       = 16;
    localparam int          PLLCS_LOCK_EDGES  = 16;
    localparam int          PLLCS_CLK_NS      = 20;
    localparam int          PLLCS_RING_HALF_NS = 200;
    localparam int          PLLCS_RING_HALF   = (PLLCS_RING_HALF_NS / PLLCS_CLK_NS < 1) ? 1 :
                                                PLLCS_RING_HALF_NS / PLLCS_CLK_NS;
    localparam int          PLLCS_RING_W      = 8;

    typedef enum logic [1:0] {
        PLLCS_SRC_REF  = 2'b00,
        PLLCS_SRC_PLL  = 2'b01,
        PLLCS_SRC_RING = 2'b10
    } pllcs_src_t;
endpackage : pllcs_pkg

// *** design/pllcs_if.sv ***
// Signals between the source selector and the loop core
`timescale 1ns/10ps
`default_nettype none
interface pllcs_if;
    import pllcs_pkg::*;
    logic                  power;
    logic                  restart;
    logic                  ref_rise;
    logic [PLLCS_M_W-1:0]  m_val;
    logic [PLLCS_NV_W-1:0] n_val;
    logic                  lock;
    logic                  vco_half;

    modport core (input power, input restart, input ref_rise,
                  input m_val, input n_val, output lock, output vco_half);
    modport ctrl (output power, output restart, output ref_rise,
                  output m_val, output n_val, input lock, input vco_half);
endinterface : pllcs_if
`default_nettype wire

// *** design/pllcs_core.sv ***
// Behavioural loop core: period meter, lock detector and divided VCO
`timescale 1ns/10ps
`default_nettype none
module pllcs_core
    import pllcs_pkg::*;
#(
    parameter int LOCK_EDGES = PLLCS_LOCK_EDGES
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    pllcs_if.core     bus
);
    localparam int ACC_W = PLLCS_PER_W + PLLCS_NV_W + 1;

    logic [PLLCS_PER_W-1:0] per_cnt;
    logic [PLLCS_PER_W-1:0] per_len;
    logic                   per_ok;
    logic                   seen_edge;
    logic [7:0]             lock_cnt;
    logic [ACC_W-1:0]       acc;
    logic                   lock;
    logic                   vco_half;

    wire                    per_full  = &per_cnt;
    wire [ACC_W-1:0]        limit     = ACC_W'(bus.n_val) * ACC_W'(per_len);
    wire [ACC_W-1:0]        acc_sum   = acc + ACC_W'(bus.m_val);
    wire                    wrap      = acc_sum >= limit;
    wire                    run       = bus.power & per_ok;
    wire                    lock_hit  = bus.ref_rise && (lock_cnt == 8'(LOCK_EDGES - 1));

    assign bus.lock     = lock;
    assign bus.vco_half = vco_half;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            per_cnt   <= '0;
            per_len   <= '0;
            per_ok    <= 1'b0;
            seen_edge <= 1'b0;
        end else if (bus.ref_rise) begin
            per_cnt   <= '0;
            per_len   <= per_cnt + 1'b1;
            seen_edge <= 1'b1;
            per_ok    <= seen_edge;
        end else if (per_full) begin
            per_ok    <= 1'b0;
            seen_edge <= 1'b0;
        end else begin
            per_cnt   <= per_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lock_cnt <= '0;
            lock     <= 1'b0;
        end else if (bus.restart || !bus.power) begin
            lock_cnt <= '0;
            lock     <= 1'b0;
        end else if (!lock && bus.ref_rise && per_ok) begin
            lock_cnt <= lock_cnt + 1'b1;
            lock     <= lock_hit;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            acc      <= '0;
            vco_half <= 1'b0;
        end else if (!run) begin
            acc      <= '0;
            vco_half <= 1'b0;
        end else if (wrap) begin
            acc      <= acc_sum - limit;
            vco_half <= ~vco_half;
        end else begin
            acc      <= acc_sum;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    lock_needs_power_a: assert property (lock |-> bus.power)
        else $error("lock set while powered down");
    no_ref_still_a: assert property (!run |=> !vco_half)
        else $error("vco output running without reference");
    lock_sticky_a: assert property (lock && bus.power && !bus.restart |=> lock)
        else $error("lock dropped without write");
endmodule : pllcs_core
`default_nettype wire

// *** design/unused_placeholder_none.sv ***
// Intentionally minimal: no further logic
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// *** dv/pllcs_top_tb.sv ***
// Self-checking testbench for the clock synthesizer top module
`timescale 1ns/10ps
`default_nettype none
module pllcs_top_tb
    import pllcs_pkg::*;
;
    logic                    clk_sys;
    logic                    reset;
    logic                    ref_clock_in;
    logic                    ctrl_write;
    logic [PLLCS_CTRL_W-1:0] ctrl_wdata;
    logic                    ring_osc_select;
    logic                    clock_halt;
    logic                    proc_clock;
    logic                    clock_out_pin;
    logic                    loop_locked;
    logic                    pll_select;
    logic                    pll_power_enable;
    logic [PLLCS_LF_W-1:0]   loop_filter_setting;
    logic [PLLCS_CTRL_W-1:0] ctrl_rdata;
    pllcs_src_t              clock_source;
    logic                    ring_osc_enable;
    int                      miscompares;
    int                      samples_checked;
    int                      cycles;
    int                      n;

    // Short lock and ring counts keep the run brief
    pllcs_top #(.LOCK_EDGES(4), .RING_HALF(2)) pllcs_top_i (
        .clk_sys(clk_sys), .reset(reset), .ref_clock_in(ref_clock_in),
        .ctrl_write(ctrl_write), .ctrl_wdata(ctrl_wdata),
        .ring_osc_select(ring_osc_select), .clock_halt(clock_halt),
        .proc_clock(proc_clock), .clock_out_pin(clock_out_pin),
        .loop_locked(loop_locked), .pll_select(pll_select),
        .pll_power_enable(pll_power_enable), .loop_filter_setting(loop_filter_setting),
        .ctrl_rdata(ctrl_rdata), .clock_source(clock_source),
        .ring_osc_enable(ring_osc_enable)
    );

    always #10 clk_sys = ~clk_sys;
    // Reference period 400 ns, 20 system cycles; edges fall on system falling edges
    always #200 ref_clock_in = ~ref_clock_in;

    task close_out();
        $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            $display("Error at %0t: run did not finish", $time);
            close_out();
        end
    end

    task check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task wr(input logic [15:0] w);
        @(negedge clk_sys);
        ctrl_write = 1'b1;
        ctrl_wdata = w;
        @(negedge clk_sys);
        ctrl_write = 1'b0;
    endtask : wr

    // Counts processor clock rises; the pin copy must match throughout
    task rises(input int cyc, input int lo, input int hi);
        logic last;
        logic pin_ok;
        n = 0;
        last = proc_clock;
        pin_ok = 1'b1;
        repeat (cyc) begin
            @(negedge clk_sys);
            if (proc_clock === 1'b1 && last === 1'b0) n++;
            if (clock_out_pin !== proc_clock) pin_ok = 1'b0;
            last = proc_clock;
        end
        check({15'h0, pin_ok}, 16'h1);
        check({15'h0, (n >= lo && n <= hi)}, 16'h1);
    endtask : rises

    // Switch latency depends on both waveforms, so bound the wait only
    task wait_src(input pllcs_src_t s);
        int i;
        for (i = 0; i < 2000 && clock_source !== s; i++) @(negedge clk_sys);
        check({14'h0, clock_source}, {14'h0, s});
    endtask : wait_src

    task wait_lock();
        int i;
        for (i = 0; i < 2000 && loop_locked !== 1'b1; i++) @(negedge clk_sys);
        check({15'h0, loop_locked}, 16'h1);
    endtask : wait_lock

    initial begin
        clk_sys = 1'b0;
        ref_clock_in = 1'b0;
        reset = 1'b1;
        ctrl_write = 1'b0;
        ctrl_wdata = 16'h0000;
        ring_osc_select = 1'b0;
        clock_halt = 1'b0;
        cycles = 0;
        miscompares = 0;
        samples_checked = 0;
        repeat (4) @(negedge clk_sys);
        reset = 1'b0;
        check(ctrl_rdata, PLLCS_CTRL_RESET);
        check({pll_select, pll_power_enable, loop_locked, ring_osc_enable}, 16'h0);
        check({14'h0, clock_source}, {14'h0, PLLCS_SRC_REF});
        rises(200, 9, 11);
        $display("Test reset and reference done");
        wr(16'h2912);
        check(ctrl_rdata, 16'h2912);
        check({12'h0, loop_filter_setting}, 16'h9);
        check({pll_select, pll_power_enable}, 16'h0);
        repeat (300) @(negedge clk_sys);
        check({15'h0, loop_locked}, 16'h0);
        wr(16'hA912);
        check({pll_power_enable, loop_locked}, 16'h2);
        wait_lock();
        check({14'h0, clock_source}, {14'h0, PLLCS_SRC_REF});
        wr(16'hE912);
        check({pll_select, loop_locked}, 16'h2);
        wait_lock();
        wait_src(PLLCS_SRC_PLL);
        // M=20, N=2: five times the reference, a 4-cycle period
        rises(200, 45, 55);
        $display("Test lock and select done");
        wr(16'hA912);
        wait_src(PLLCS_SRC_REF);
        rises(200, 9, 11);
        // M=4, N=1 coded as 7: twice the reference, a 10-cycle period
        wr(16'h88E2);
        check(ctrl_rdata, 16'h88E2);
        wait_lock();
        wr(16'hC8E2);
        wait_lock();
        wait_src(PLLCS_SRC_PLL);
        rises(200, 18, 22);
        $display("Test divider codes done");
        ring_osc_select = 1'b1;
        wait_src(PLLCS_SRC_RING);
        check({15'h0, ring_osc_enable}, 16'h1);
        rises(200, 45, 55);
        clock_halt = 1'b1;
        repeat (20) @(negedge clk_sys);
        rises(200, 0, 0);
        ring_osc_select = 1'b0;
        wait_src(PLLCS_SRC_PLL);
        check({15'h0, ring_osc_enable}, 16'h0);
        rises(200, 0, 0);
        check({pll_power_enable, loop_locked}, 16'h3);
        clock_halt = 1'b0;
        repeat (20) @(negedge clk_sys);
        rises(200, 18, 22);
        $display("Test ring and halt done");
        // Selected but unpowered: the loop gives nothing and lock stays clear
        wr(16'h48E2);
        check({pll_select, pll_power_enable}, 16'h2);
        repeat (300) @(negedge clk_sys);
        check({15'h0, loop_locked}, 16'h0);
        rises(200, 0, 0);
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        check(ctrl_rdata, PLLCS_CTRL_RESET);
        check({14'h0, clock_source}, {14'h0, PLLCS_SRC_REF});
        reset = 1'b0;
        rises(200, 9, 11);
        $display("Test power down and second reset done");
        close_out();
    end
endmodule : pllcs_top_tb
`default_nettype wire
